// File: cms_defs.vh
// register map, field positions, reset values and timing counts
`ifndef CMS_DEFS_VH
`define CMS_DEFS_VH
// byte offsets
`define CMS_A_CTRL1       8'h00
`define CMS_A_CTRL2       8'h04
`define CMS_A_STATUS      8'h08
`define CMS_A_ISTAT       8'h0c
`define CMS_A_IMASK       8'h10
// clock_gen_control_one fields
`define CMS_F_MODE_LO     0
`define CMS_F_MODE_HI     1
`define CMS_F_REFSEL      2
`define CMS_F_GEN_EN      3
// clock_gen_control_two fields
`define CMS_F_MF_LO       0
`define CMS_F_MF_HI       2
`define CMS_F_RDIV_LO     4
`define CMS_F_RDIV_HI     6
// status fields: [1:0] mode, 2 dco, 3 ext ref, 4 lock, 5 loss of clock
`define CMS_F_ST_DCO      2
// interrupt bits
`define CMS_I_MODE        0
`define CMS_I_LOCK        1
`define CMS_I_LOC         2
// mode codes
`define CMS_M_SELF        2'b00
`define CMS_M_FLL_INT     2'b01
`define CMS_M_BYP_EXT     2'b10
`define CMS_M_FLL_EXT     2'b11
// reset values
`define CMS_RST_MODE      2'b00
`define CMS_RST_REFSEL    1'b1
`define CMS_RST_GEN_EN    1'b1
`define CMS_RST_MF        3'h0
`define CMS_RST_RDIV      3'h0
`define CMS_RST_IMASK     3'h0
// internal reference divided by this for the dco comparison
`define CMS_REF_DIV       3'h7
// bus cycles a new mode must stand before status follows
`define CMS_UPD_CYC       4'h8
`endif

// File: cms_clock_mode_selector.v
// clock mode selection, status and output clock divider behind apb
//
// Function
// - two-bit request and status: 00 self, 01 fll int, 10 bypass, 11 fll ext
// - status equals request when its conditions hold, else the real mode
// - status follows a request only after several bus cycles
// - reference select bit takes only the first write after reset
// - reference select left at 0 keeps the crystal amplifier off
// - self-clocked output ignores reference; internal ref /7 still sets dco
// - fll external outputs dco/2R while locking or relocking, dco/R locked
`timescale 1ns/1ns
`include "cms_defs.vh"

module cms_clock_mode_selector (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // clocks and status from the oscillators and fll
  input  wire        dco_clock,
  input  wire        external_ref_clock,
  input  wire        internal_ref_clock,
  input  wire        external_ref_status,
  input  wire        fll_lock,
  input  wire        loss_of_clock_status,
  // outputs
  output reg         generator_output_clock,
  output reg         xtal_amp_enable,
  output reg         irq
);

  localparam NSYNC = 6;

  // one-hot register select, shared by read and write paths
  function [4:0] reg_sel;
    input [7:0] a;
    begin
      case (a)
        `CMS_A_CTRL1:  reg_sel = 5'h01;
        `CMS_A_CTRL2:  reg_sel = 5'h02;
        `CMS_A_STATUS: reg_sel = 5'h04;
        `CMS_A_ISTAT:  reg_sel = 5'h08;
        `CMS_A_IMASK:  reg_sel = 5'h10;
        default:       reg_sel = 5'h00;
      endcase
    end
  endfunction

  // mode the hardware may actually run for a request
  function [1:0] target_mode;
    input [1:0] req;
    input       dco;
    input       ext;
    begin
      case (req)
        `CMS_M_FLL_INT:
          target_mode = dco ? `CMS_M_FLL_INT : `CMS_M_SELF;
        `CMS_M_BYP_EXT:
          target_mode = ext ? `CMS_M_BYP_EXT : `CMS_M_SELF;
        `CMS_M_FLL_EXT:
          target_mode = (dco & ext) ? `CMS_M_FLL_EXT : `CMS_M_SELF;
        default:        target_mode = `CMS_M_SELF;
      endcase
    end
  endfunction

  // two-flop synchronisers; s3 is a third stage for edge detection
  // source clocks must stay below half of pclk to be counted
  wire [NSYNC-1:0] async_in;
  reg  [NSYNC-1:0] s1;
  reg  [NSYNC-1:0] s2;
  reg  [NSYNC-1:0] s3;
  assign async_in = {loss_of_clock_status, fll_lock, external_ref_status,
                     internal_ref_clock, external_ref_clock, dco_clock};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1[gi] <= 1'b0;
          s2[gi] <= 1'b0;
          s3[gi] <= 1'b0;
        end else begin
          s1[gi] <= async_in[gi];
          s2[gi] <= s1[gi];
          s3[gi] <= s2[gi];
        end
      end
    end
  endgenerate

  // detectors start from the idle low level; a clock high at release
  // gives one stray edge, which shifts the first dco window; a stray dco edge also steps the output divider
  wire dco_edge  = s2[0] ^ s3[0];
  wire ext_edge  = s2[1] ^ s3[1];
  wire iref_rise = s2[2] & ~s3[2];
  wire ext_ok    = s2[3];
  wire lock_rise = s2[4] & ~s3[4];
  wire loss_now  = s2[5];
  wire loss_rise = s2[5] & ~s3[5];

  // apb decode
  wire [4:0] reg_hit   = reg_sel(paddr);
  wire       setup_cyc = psel & ~penable;
  wire       acc       = psel & penable & pready;
  // a refused access carries pslverr, so its write is dropped here
  wire       wr        = acc & pwrite & ~pslverr;
  wire       wr_c1     = wr & reg_hit[0];
  wire       wr_c2     = wr & reg_hit[1];
  wire       wr_ist    = wr & reg_hit[3];
  wire       wr_msk    = wr & reg_hit[4];

  // control state
  reg  [1:0] mode_req;
  reg        ref_sel;
  reg        ref_written;
  reg        gen_en;
  reg  [2:0] mult;
  reg  [2:0] rdiv;
  reg  [1:0] mode_stat;
  reg  [3:0] upd_cnt;
  reg        locked;
  reg        dco_ok;
  reg        dco_seen;
  reg  [2:0] ref7_cnt;
  reg  [8:0] div_cnt;
  reg  [2:0] istat;
  reg  [2:0] imask;

  // full external mode without its reference falls back to self-clocked
  wire [1:0] tgt = target_mode(mode_req, dco_ok, ext_ok);
  // one decision drives both the status update and its event
  wire mode_commit = (tgt != mode_stat) &&
                     (upd_cnt == `CMS_UPD_CYC - 4'h1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_req    <= `CMS_RST_MODE;
      ref_sel     <= `CMS_RST_REFSEL;
      ref_written <= 1'b0;
      gen_en      <= `CMS_RST_GEN_EN;
      mult        <= `CMS_RST_MF;
      rdiv        <= `CMS_RST_RDIV;
      imask       <= `CMS_RST_IMASK;
    end else begin
      // mode request and enable stay writable at any time
      if (wr_c1) begin
        mode_req <= pwdata[`CMS_F_MODE_HI:`CMS_F_MODE_LO];
        gen_en   <= pwdata[`CMS_F_GEN_EN];
        if (!ref_written) begin
          ref_sel     <= pwdata[`CMS_F_REFSEL];
          ref_written <= 1'b1;
        end
      end
      if (wr_c2) begin
        mult <= pwdata[`CMS_F_MF_HI:`CMS_F_MF_LO];
        rdiv <= pwdata[`CMS_F_RDIV_HI:`CMS_F_RDIV_LO];
      end
      if (wr_msk)
        imask <= pwdata[2:0];
    end
  end

  // amplifier stays off until the next reset once a zero select has been taken
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      xtal_amp_enable <= 1'b0;
    else
      xtal_amp_enable <= ref_sel & mode_req[1];
  end

  // dco check against internal reference over seven reference periods;
  // runs in every mode, self-clocked included
  // a dead dco clears dco_ok at the end of the first window with no dco edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref7_cnt <= 3'h0;
      dco_seen <= 1'b0;
      dco_ok   <= 1'b0;
    end else if (iref_rise) begin
      if (ref7_cnt == `CMS_REF_DIV - 3'h1) begin
        ref7_cnt <= 3'h0;
        dco_ok   <= dco_seen | dco_edge;
        dco_seen <= 1'b0;
      end else begin
        ref7_cnt <= ref7_cnt + 3'h1;
        dco_seen <= dco_seen | dco_edge;
      end
    end else if (dco_edge) begin
      dco_seen <= 1'b1;
    end
  end

  // status follows the target once it has differed from status for the delay;
  // a target that flips back restarts the wait
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_stat <= `CMS_M_SELF;
      upd_cnt   <= 4'h0;
    end else if (tgt == mode_stat) begin
      upd_cnt <= 4'h0;
    end else if (mode_commit) begin
      mode_stat <= tgt;
      upd_cnt   <= 4'h0;
    end else begin
      upd_cnt <= upd_cnt + 4'h1;
    end
  end

  // lock drops when the multiply factor changes, returns on a new lock
  // rewriting the same factor keeps lock; only a change forces relock
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      locked <= 1'b0;
    else if (wr_c2 && pwdata[`CMS_F_MF_HI:`CMS_F_MF_LO] != mult)
      locked <= 1'b0;
    else if (lock_rise)
      locked <= 1'b1;
  end

  // output divider counts both edges of the source: R edges per half
  // period gives source/R; limited to the pclk sampling rate
  // a new divisor applies to the half period in progress; disabling the
  // generator parks the counter so the clock restarts from low
  wire [8:0] r_val   = 9'h001 << rdiv;
  wire [8:0] half    = (mode_stat == `CMS_M_FLL_EXT && !locked) ?
                       {r_val[7:0], 1'b0} : r_val;
  wire       src_edg = (mode_stat == `CMS_M_BYP_EXT) ? ext_edge : dco_edge;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt                <= 9'h000;
      generator_output_clock <= 1'b0;
    end else if (!gen_en) begin
      div_cnt                <= 9'h000;
      generator_output_clock <= 1'b0;
    end else if (src_edg) begin
      if (div_cnt + 9'h001 >= half) begin
        div_cnt                <= 9'h000;
        generator_output_clock <= ~generator_output_clock;
      end else begin
        div_cnt <= div_cnt + 9'h001;
      end
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  wire [2:0] ev;
  assign ev[`CMS_I_MODE] = mode_commit;
  assign ev[`CMS_I_LOCK] = lock_rise;
  assign ev[`CMS_I_LOC]  = loss_rise;
  wire [2:0] clr = wr_ist ? pwdata[2:0] : 3'h0;
  wire [2:0] next_istat = (istat & ~clr) | ev;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat <= 3'h0;
      irq   <= 1'b0;
    end else begin
      istat <= next_istat;
      irq   <= |(next_istat & imask);
    end
  end

  // read data captured in the setup cycle so the access needs no wait
  reg [31:0] next_prdata;
  always @* begin
    next_prdata = 32'h0;
    case (1'b1)
      reg_hit[0]: next_prdata[3:0] = {gen_en, ref_sel, mode_req};
      reg_hit[1]: next_prdata[6:0] = {rdiv, 1'b0, mult};
      // status bits are a snapshot taken in the setup cycle
      reg_hit[2]: next_prdata[5:0] = {loss_now, locked, ext_ok, dco_ok,
                                      mode_stat};
      reg_hit[3]: next_prdata[2:0] = istat;
      reg_hit[4]: next_prdata[2:0] = imask;
      default:  next_prdata = 32'h0;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup_cyc;
      pslverr <= setup_cyc & ~(|reg_hit);
      if (setup_cyc & ~pwrite)
        prdata <= next_prdata;
    end
  end

endmodule // cms_clock_mode_selector

// File: cms_clock_mode_selector_props.sv
// bus-side assertions for the clock mode selector
`timescale 1ns/1ns
module cms_props (
  // apb
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // status outputs
  input logic        xtal_amp_enable,
  input logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire setup = psel && !penable;
  wire rd_ok = pready && !pwrite;
  chk_ready_after_setup:
    assert property (setup |=> pready) else $error("ready late");
  chk_ready_one_cycle:
    assert property (pready |=> !pready) else $error("ready too long");
  chk_err_with_ready:
    assert property (pslverr |-> pready) else $error("stray error");
  chk_bad_addr_err:
    assert property (setup && paddr > 8'h10 |=> pslverr)
      else $error("unmapped not refused");
  chk_good_addr_ok:
    assert property (setup && paddr <= 8'h10 && paddr[1:0] == 2'b00
      |=> !pslverr) else $error("mapped refused");
  chk_status_upper_zero:
    assert property (rd_ok && paddr == 8'h08 |-> prdata[31:6] == 26'h0)
      else $error("status upper bits set");
  chk_err_read_zero:
    assert property (rd_ok && pslverr |-> prdata == 32'h0)
      else $error("refused read not zero");
  chk_rdata_holds:
    assert property (!(setup && !pwrite) |=> $stable(prdata))
      else $error("read data moved");
  chk_ctrl_upper_zero:
    assert property (rd_ok && paddr == 8'h00 |-> prdata[31:4] == 28'h0)
      else $error("control upper bits set");
  cover property (pslverr);
  cover property ($rose(irq));
  cover property ($rose(xtal_amp_enable));
endmodule // cms_props
bind cms_clock_mode_selector cms_props u_cms_props (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .xtal_amp_enable, .irq);

// File: cms_ref_model.sv
// far-side model: reference, dco and fll lock sources
`timescale 1ns/1ns
module cms_ref_model (
  // bench controls
  input  wire logic ext_on,
  input  wire logic dco_on,
  input  wire logic lock_on,
  input  wire logic loc_on,
  // toward the selector
  output logic      external_ref_clock,
  output logic      dco_clock,
  output logic      internal_ref_clock,
  output logic      external_ref_status,
  output logic      fll_lock,
  output logic      loss_of_clock_status
);
  initial external_ref_clock = 1'b0;
  initial dco_clock = 1'b0;
  initial internal_ref_clock = 1'b0;
  // a stopped oscillator sits low rather than holding its last phase
  always #200 external_ref_clock = ext_on & ~external_ref_clock;
  always #140 dco_clock = dco_on & ~dco_clock;
  always #80 internal_ref_clock = ~internal_ref_clock;
  assign external_ref_status = ext_on;
  assign fll_lock = lock_on & dco_on;
  assign loss_of_clock_status = loc_on;
endmodule // cms_ref_model

// File: tb_clock_mode_selector.sv
// self-checking bench for the clock mode selector
`timescale 1ns/1ns
`include "cms_defs.vh"
module tb_clock_mode_selector;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]  paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic        pready, pslverr, err, ext_on = 0, dco_on = 0, lock_on = 0;
  logic        loc_on = 0;
  logic        erc, dcc, irc, ers, lck, loc, gout, xtal, irq;
  int          n_errors = 0, num_checks = 0, n_out = 0, n_ext = 0;
  int          n_dco = 0, cyc = 0, o0, s0;
  cms_clock_mode_selector u_cms_clock_mode_selector (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dco_clock(dcc), .external_ref_clock(erc),
    .internal_ref_clock(irc), .external_ref_status(ers), .fll_lock(lck),
    .loss_of_clock_status(loc), .generator_output_clock(gout),
    .xtal_amp_enable(xtal), .irq(irq));
  cms_ref_model u_cms_ref_model (.ext_on(ext_on), .dco_on(dco_on),
    .lock_on(lock_on), .loc_on(loc_on), .external_ref_clock(erc),
    .dco_clock(dcc),
    .internal_ref_clock(irc), .external_ref_status(ers), .fll_lock(lck),
    .loss_of_clock_status(loc));
  initial forever #10 pclk = ~pclk;
  always @(posedge gout) n_out++;
  always @(posedge erc) n_ext++;
  always @(posedge dcc) n_dco++;
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(q, e);
  endtask
  task automatic rst;
    presetn <= 0;
    repeat (10) @(posedge pclk);
    presetn <= 1;
  endtask
  // output rises against source rises, allowing one output rise plus one source rise of slop
  task automatic ratio(input logic use_ext, input int k);
    o0 = n_out;
    s0 = use_ext ? n_ext : n_dco;
    repeat (600) @(posedge pclk);
    s0 = (use_ext ? n_ext : n_dco) - s0;
    chk(32'(((n_out - o0) * k - s0) inside {[-k-1:k+1]}), 32'h1);
  endtask
  initial begin
    rst();
    rd(`CMS_A_CTRL1, 32'h0c);
    wr(`CMS_A_CTRL1, 32'h0b);
    wr(`CMS_A_CTRL1, 32'h0f);
    rd(`CMS_A_CTRL1, 32'h0b);
    repeat (20) @(posedge pclk);
    chk(xtal, 1'b0);
    rd(`CMS_A_STATUS, 32'h00);
    rst();
    ext_on <= 1;
    wr(`CMS_A_CTRL1, 32'h0e);
    rd(`CMS_A_STATUS, 32'h08);
    repeat (12) @(posedge pclk);
    chk(xtal, 1'b1);
    rd(`CMS_A_STATUS, 32'h0a);
    wr(`CMS_A_CTRL2, 32'h10);
    ratio(1, 2);
    dco_on <= 1;
    wr(`CMS_A_CTRL1, 32'h09);
    repeat (200) @(posedge pclk);
    rd(`CMS_A_STATUS, 32'h0d);
    wr(`CMS_A_CTRL1, 32'h0b);
    repeat (20) @(posedge pclk);
    rd(`CMS_A_STATUS, 32'h0f);
    ratio(0, 4);
    lock_on <= 1;
    repeat (10) @(posedge pclk);
    ratio(0, 2);
    wr(`CMS_A_CTRL2, 32'h11);
    rd(`CMS_A_STATUS, 32'h0f);
    ratio(0, 4);
    lock_on <= 0;
    repeat (5) @(posedge pclk);
    lock_on <= 1;
    repeat (10) @(posedge pclk);
    rd(`CMS_A_ISTAT, 32'h03);
    chk(irq, 1'b0);
    wr(`CMS_A_IMASK, 32'h01);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b1);
    wr(`CMS_A_ISTAT, 32'h01);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0);
    rd(`CMS_A_ISTAT, 32'h02);
    ext_on <= 0;
    repeat (20) @(posedge pclk);
    rd(`CMS_A_STATUS, 32'h14);
    chk(irq, 1'b1);
    ratio(0, 2);
    wr(`CMS_A_STATUS, 32'hff);
    rd(`CMS_A_STATUS, 32'h14);
    loc_on <= 1;
    repeat (5) @(posedge pclk);
    rd(`CMS_A_STATUS, 32'h34);
    rd(`CMS_A_ISTAT, 32'h07);
    wr(`CMS_A_ISTAT, 32'h07);
    rd(`CMS_A_ISTAT, 32'h00);
    chk(irq, 1'b0);
    rd(8'h20, 32'h0);
    chk(err, 1'b1);
    wr(`CMS_A_CTRL1, 32'h03);
    repeat (5) @(posedge pclk);
    o0 = n_out;
    repeat (100) @(posedge pclk);
    chk(n_out - o0, 32'h0);
    chk(gout, 1'b0);
    end_of_test();
  end
endmodule // tb_clock_mode_selector
